// ==== hw/mae_regs.vh ====
// Register map, field positions, reset values and timing of the alarm block
`ifndef MAE_REGS_VH
`define MAE_REGS_VH

// ==========================================================================
// Register byte offsets
`define MAE_UNARY_CTRL  8'h00
`define MAE_DIG_CTRL    8'h04
`define MAE_STD_CTRL    8'h08
`define MAE_DIG_PU_DLY  8'h0c
`define MAE_DIG_DO_DLY  8'h10
`define MAE_STD_PU_DLY  8'h14
`define MAE_STD_DO_DLY  8'h18
`define MAE_STD_PU_LIM  8'h1c
`define MAE_STD_DO_LIM  8'h20
`define MAE_UNARY_HOLD  8'h24
`define MAE_STATE       8'h28
`define MAE_IRQ_STATUS  8'h2c
`define MAE_IRQ_CLEAR   8'h30
`define MAE_IRQ_ENABLE  8'h34
`define MAE_UNARY_ACK   8'h38

// ==========================================================================
// Common control fields
`define MAE_F_EN        0
`define MAE_F_PRIO_LO   1
`define MAE_F_OUT_LO    3
// Unary mode field, digital pickup state, standard options
`define MAE_F_MODE_LO   5
`define MAE_F_PU_STATE  5
`define MAE_F_UNDER     5
`define MAE_F_PF_MODE   6
`define MAE_F_PU_QUAD   7
`define MAE_F_DO_QUAD   8

// ==========================================================================
// Encodings and reset values
`define MAE_PRIO_NONE   2'h0
`define MAE_MODE_NORMAL 2'h0
`define MAE_MODE_TIMED  2'h1
`define MAE_MODE_COIL   2'h2
`define MAE_CTRL_RST    32'h0000_0000
`define MAE_DLY_RST     20'h0_0000
`define MAE_DLY_MAX     20'hf_423f
`define MAE_LIM_RST     32'h0000_0000
`define MAE_LIM_FRAC    8
`define MAE_STAT_W      7
`define MAE_ST_REJECT   6

// ==========================================================================
// Timing
`define MAE_TICK_MS     1000
`define MAE_CLK_KHZ     125000
`define MAE_TICK_CYCLES (`MAE_TICK_MS * `MAE_CLK_KHZ)

`endif

// ==== hw/mae_tick_gen.v ====
// One-second evaluation tick generator
`timescale 1ns/1ps

module mae_tick_gen #(
  parameter TICK_CYCLES = 125000000
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Tick out
  output reg         tick_ff
);

  reg  [31:0] cnt_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff  <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end
    else if (cnt_ff == TICK_CYCLES - 1)
    begin
      cnt_ff  <= 32'h0000_0000;
      tick_ff <= 1'b1;
    end
    else
    begin
      cnt_ff  <= cnt_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
    end
  end

endmodule // mae_tick_gen

// ==== hw/mae_delay_qual.v ====
// Pickup and dropout delay qualifier for one alarm
`timescale 1ns/1ps

module mae_delay_qual #(
  parameter DW = 20
) (
  // Clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // Control
  input  wire          enable,
  input  wire          tick,
  input  wire          pu_cond,
  input  wire          do_cond,
  input  wire [DW-1:0] pu_dly,
  input  wire [DW-1:0] do_dly,
  // State and events
  output reg           tripped_ff,
  output reg           trip_pulse_ff,
  output reg           clear_pulse_ff
);

  reg  [DW-1:0] cnt_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff         <= {DW{1'b0}};
      tripped_ff     <= 1'b0;
      trip_pulse_ff  <= 1'b0;
      clear_pulse_ff <= 1'b0;
    end
    else if (!enable)
    begin
      // Disabled: silent, no clear event logged
      cnt_ff         <= {DW{1'b0}};
      tripped_ff     <= 1'b0;
      trip_pulse_ff  <= 1'b0;
      clear_pulse_ff <= 1'b0;
    end
    else
    begin
      trip_pulse_ff  <= 1'b0;
      clear_pulse_ff <= 1'b0;
      if (tick)
      begin
        if (!tripped_ff)
        begin
          if (!pu_cond)
            cnt_ff <= {DW{1'b0}};
          else if (cnt_ff >= pu_dly)
          begin
            cnt_ff        <= {DW{1'b0}};
            tripped_ff    <= 1'b1;
            trip_pulse_ff <= 1'b1;
          end
          else
            cnt_ff <= cnt_ff + {{(DW-1){1'b0}}, 1'b1};
        end
        else
        begin
          if (!do_cond)
            cnt_ff <= {DW{1'b0}};
          else if (cnt_ff >= do_dly)
          begin
            cnt_ff         <= {DW{1'b0}};
            tripped_ff     <= 1'b0;
            clear_pulse_ff <= 1'b1;
          end
          else
            cnt_ff <= cnt_ff + {{(DW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // mae_delay_qual

// ==== hw/mae_alarm_eval.v ====
// Alarm evaluator: unary, digital and standard alarms with AXI4-Lite regs
`timescale 1ns/1ps
`include "mae_regs.vh"

module mae_alarm_eval #(
  parameter TICK_CYCLES = `MAE_TICK_CYCLES,
  parameter DW          = 20
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Monitored inputs
  input  wire        unary_event,
  input  wire        dig_input_pin,
  input  wire [31:0] meas_value,
  input  wire        pf_lead,
  input  wire        panel_cfg_write,
  input  wire        basic_cfg_change,
  // Relays, logging, indication, interrupt
  output reg         relay_output_first_ff,
  output reg         relay_output_second_ff,
  output reg  [2:0]  alarm_log_stb_ff,
  output reg  [2:0]  event_log_stb_ff,
  output reg  [2:0]  log_pickup_ff,
  output reg         alarm_indicate_ff,
  output wire        irq
);

  // ========================================================================
  // Helpers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  strb;
    integer      i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function [DW-1:0] clamp_dly;
    input [31:0] v;
    begin
      if (v > {12'h000, `MAE_DLY_MAX})
        clamp_dly = `MAE_DLY_MAX;
      else
        clamp_dly = v[DW-1:0];
    end
  endfunction

  function lim_ok;
    input        under;
    input [31:0] pu;
    input [31:0] dn;
    begin
      lim_ok = under ? ($signed(dn) >= $signed(pu))
                     : ($signed(dn) <= $signed(pu));
    end
  endfunction

  // ========================================================================
  // Registers
  reg  [31:0]   un_ctrl_ff;
  reg  [31:0]   dg_ctrl_ff;
  reg  [31:0]   sd_ctrl_ff;
  reg  [DW-1:0] dg_pu_dly_ff;
  reg  [DW-1:0] dg_do_dly_ff;
  reg  [DW-1:0] sd_pu_dly_ff;
  reg  [DW-1:0] sd_do_dly_ff;
  reg  [DW-1:0] un_hold_ff;
  reg  [31:0]   sd_pu_lim_ff;
  reg  [31:0]   sd_do_lim_ff;
  reg  [`MAE_STAT_W-1:0] stat_ff;
  reg  [`MAE_STAT_W-1:0] ien_ff;
  reg           aw_got_ff;
  reg           w_got_ff;
  reg  [7:0]    awaddr_ff;
  reg  [31:0]   wdata_ff;
  reg  [3:0]    wstrb_ff;
  reg           dig_meta_ff;
  reg           dig_sync_ff;
  reg           un_trip_ff;
  reg  [DW-1:0] un_cnt_ff;
  reg           un_evt_ff;
  reg  [2:0]    nxt_alarm_log;
  reg  [2:0]    nxt_event_log;
  reg  [31:0]   nxt_rdata;
  reg           nxt_rerr;

  wire          tick;
  wire          dg_trip;
  wire          sd_trip;
  wire [2:0]    trip_evt;
  wire [2:0]    clr_evt;

  // ========================================================================
  // AXI4-Lite write path
  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire aw_have  = aw_got_ff | aw_hs;
  wire w_have   = w_got_ff | w_hs;
  wire wr_fire  = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0]  wa = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_got_ff ? wdata_ff : s_axi_wdata;
  wire [3:0]  ws = w_got_ff ? wstrb_ff : s_axi_wstrb;

  assign s_axi_awready = ~aw_got_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_ff & ~s_axi_bvalid;

  wire wr_un   = wr_fire & (wa == `MAE_UNARY_CTRL);
  wire wr_dg   = wr_fire & (wa == `MAE_DIG_CTRL);
  wire wr_sd   = wr_fire & (wa == `MAE_STD_CTRL);
  wire wr_ack  = wr_fire & (wa == `MAE_UNARY_ACK);
  wire wr_iclr = wr_fire & (wa == `MAE_IRQ_CLEAR);
  wire [31:0] sd_new = merge(sd_ctrl_ff, wd, ws);
  // Enabling a standard alarm with inconsistent limits is refused
  wire sd_reject = wr_sd & sd_new[`MAE_F_EN] & ~sd_ctrl_ff[`MAE_F_EN] &
                   ~lim_ok(sd_new[`MAE_F_UNDER], sd_pu_lim_ff,
                           sd_do_lim_ff);
  wire wr_map  = (wa <= `MAE_UNARY_ACK) & (wa[1:0] == 2'b00) &
                 (wa != `MAE_STATE) & (wa != `MAE_IRQ_STATUS);
  wire [31:0] frac_mask = {{(32-`MAE_LIM_FRAC){1'b1}},
                           {`MAE_LIM_FRAC{1'b0}}};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      un_ctrl_ff   <= `MAE_CTRL_RST;
      dg_ctrl_ff   <= `MAE_CTRL_RST;
      sd_ctrl_ff   <= `MAE_CTRL_RST;
      dg_pu_dly_ff <= `MAE_DLY_RST;
      dg_do_dly_ff <= `MAE_DLY_RST;
      sd_pu_dly_ff <= `MAE_DLY_RST;
      sd_do_dly_ff <= `MAE_DLY_RST;
      un_hold_ff   <= `MAE_DLY_RST;
      sd_pu_lim_ff <= `MAE_LIM_RST;
      sd_do_lim_ff <= `MAE_LIM_RST;
      ien_ff       <= {`MAE_STAT_W{1'b0}};
    end
    else
    begin
      if (aw_hs & ~wr_fire)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs & ~wr_fire)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_map & ~sd_reject) ? 2'b00 : 2'b10;
        case (wa)
          `MAE_UNARY_CTRL: un_ctrl_ff   <= merge(un_ctrl_ff, wd, ws);
          `MAE_DIG_CTRL:   dg_ctrl_ff   <= merge(dg_ctrl_ff, wd, ws);
          `MAE_STD_CTRL:   sd_ctrl_ff   <= sd_reject ?
                              {sd_new[31:1], 1'b0} : sd_new;
          `MAE_DIG_PU_DLY: dg_pu_dly_ff <= clamp_dly(wd);
          `MAE_DIG_DO_DLY: dg_do_dly_ff <= clamp_dly(wd);
          `MAE_STD_PU_DLY: sd_pu_dly_ff <= clamp_dly(wd);
          `MAE_STD_DO_DLY: sd_do_dly_ff <= clamp_dly(wd);
          `MAE_UNARY_HOLD: un_hold_ff   <= clamp_dly(wd);
          `MAE_STD_PU_LIM: sd_pu_lim_ff <= merge(sd_pu_lim_ff, wd, ws);
          `MAE_STD_DO_LIM: sd_do_lim_ff <= merge(sd_do_lim_ff, wd, ws);
          `MAE_IRQ_ENABLE: ien_ff       <= wd[`MAE_STAT_W-1:0];
          default:         ;
        endcase
      end
      if (panel_cfg_write)
      begin
        // Panel entry has integer resolution only
        sd_pu_lim_ff <= sd_pu_lim_ff & frac_mask;
        sd_do_lim_ff <= sd_do_lim_ff & frac_mask;
      end
      if (basic_cfg_change)
      begin
        un_ctrl_ff[`MAE_F_EN] <= 1'b0;
        dg_ctrl_ff[`MAE_F_EN] <= 1'b0;
        sd_ctrl_ff[`MAE_F_EN] <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read path
  assign s_axi_arready = ~s_axi_rvalid;

  always @*
  begin
    nxt_rerr  = 1'b0;
    nxt_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      `MAE_UNARY_CTRL: nxt_rdata = un_ctrl_ff;
      `MAE_DIG_CTRL:   nxt_rdata = dg_ctrl_ff;
      `MAE_STD_CTRL:   nxt_rdata = sd_ctrl_ff;
      `MAE_DIG_PU_DLY: nxt_rdata = {12'h000, dg_pu_dly_ff};
      `MAE_DIG_DO_DLY: nxt_rdata = {12'h000, dg_do_dly_ff};
      `MAE_STD_PU_DLY: nxt_rdata = {12'h000, sd_pu_dly_ff};
      `MAE_STD_DO_DLY: nxt_rdata = {12'h000, sd_do_dly_ff};
      `MAE_UNARY_HOLD: nxt_rdata = {12'h000, un_hold_ff};
      `MAE_STD_PU_LIM: nxt_rdata = sd_pu_lim_ff;
      `MAE_STD_DO_LIM: nxt_rdata = sd_do_lim_ff;
      `MAE_STATE:      nxt_rdata = {27'h0, relay_output_second_ff,
                                    relay_output_first_ff, sd_trip,
                                    dg_trip, un_trip_ff};
      `MAE_IRQ_STATUS: nxt_rdata = {25'h0, stat_ff};
      `MAE_IRQ_ENABLE: nxt_rdata = {25'h0, ien_ff};
      `MAE_IRQ_CLEAR:  nxt_rdata = 32'h0000_0000;
      `MAE_UNARY_ACK:  nxt_rdata = 32'h0000_0000;
      default:         nxt_rerr  = 1'b1;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= nxt_rdata;
      s_axi_rresp  <= nxt_rerr ? 2'b10 : 2'b00;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ========================================================================
  // Tick, input synchroniser, qualifiers
  mae_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick_ff (tick)
  );

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dig_meta_ff <= 1'b0;
      dig_sync_ff <= 1'b0;
    end
    else
    begin
      dig_meta_ff <= dig_input_pin;
      dig_sync_ff <= dig_meta_ff;
    end
  end

  wire dg_pu = (dig_sync_ff == dg_ctrl_ff[`MAE_F_PU_STATE]);

  wire        sd_under = sd_ctrl_ff[`MAE_F_UNDER];
  wire        sd_pf    = sd_ctrl_ff[`MAE_F_PF_MODE];
  wire signed [31:0] mv = meas_value;
  wire sd_beyond = sd_under ? (mv < $signed(sd_pu_lim_ff))
                            : (mv > $signed(sd_pu_lim_ff));
  wire sd_back   = sd_under ? (mv > $signed(sd_do_lim_ff))
                            : (mv < $signed(sd_do_lim_ff));
  wire sd_pu = sd_beyond &
               (~sd_pf | (pf_lead == sd_ctrl_ff[`MAE_F_PU_QUAD]));
  wire sd_do = sd_back &
               (~sd_pf | (pf_lead == sd_ctrl_ff[`MAE_F_DO_QUAD]));

  // Pickup/dropout timing on the one-second tick
  mae_delay_qual #(.DW(DW)) u_dig (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .enable         (dg_ctrl_ff[`MAE_F_EN]),
    .tick           (tick),
    .pu_cond        (dg_pu),
    .do_cond        (~dg_pu),
    .pu_dly         (dg_pu_dly_ff),
    .do_dly         (dg_do_dly_ff),
    .tripped_ff     (dg_trip),
    .trip_pulse_ff  (trip_evt[1]),
    .clear_pulse_ff (clr_evt[1])
  );

  mae_delay_qual #(.DW(DW)) u_std (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .enable         (sd_ctrl_ff[`MAE_F_EN]),
    .tick           (tick),
    .pu_cond        (sd_pu),
    .do_cond        (sd_do),
    .pu_dly         (sd_pu_dly_ff),
    .do_dly         (sd_do_dly_ff),
    .tripped_ff     (sd_trip),
    .trip_pulse_ff  (trip_evt[2]),
    .clear_pulse_ff (clr_evt[2])
  );

  // ========================================================================
  // Unary alarm
  wire [1:0] un_mode = un_ctrl_ff[`MAE_F_MODE_LO +: 2];
  wire       un_en   = un_ctrl_ff[`MAE_F_EN];
  wire       un_set  = un_en & unary_event & ~un_trip_ff;
  // Normal drops at next tick, timed after hold, coil hold on ack
  wire       un_end  = un_trip_ff &
                       (((un_mode == `MAE_MODE_COIL) & wr_ack) |
                        ((un_mode != `MAE_MODE_COIL) & tick &
                         ((un_mode != `MAE_MODE_TIMED) |
                          (un_cnt_ff >= un_hold_ff))));

  always @(posedge aclk)
  begin
    if (!aresetn | ~un_en)
    begin
      un_trip_ff <= 1'b0;
      un_cnt_ff  <= `MAE_DLY_RST;
      un_evt_ff  <= 1'b0;
    end
    else
    begin
      un_evt_ff <= un_end;
      if (un_set)
      begin
        un_trip_ff <= 1'b1;
        un_cnt_ff  <= `MAE_DLY_RST;
      end
      else if (un_end)
        un_trip_ff <= 1'b0;
      else if (un_trip_ff & tick)
        un_cnt_ff <= un_cnt_ff + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  assign trip_evt[0] = un_set;
  assign clr_evt[0]  = un_evt_ff;

  // ========================================================================
  // Relays, logging, indication
  wire [1:0] un_out = un_ctrl_ff[`MAE_F_OUT_LO +: 2];
  wire [1:0] dg_out = dg_ctrl_ff[`MAE_F_OUT_LO +: 2];
  wire [1:0] sd_out = sd_ctrl_ff[`MAE_F_OUT_LO +: 2];
  wire       un_drv = un_trip_ff & (un_mode != `MAE_MODE_NORMAL);
  wire [1:0] drive  = ({2{un_drv}} & un_out) |
                      ({2{dg_trip}} & dg_out) |
                      ({2{sd_trip}} & sd_out);
  wire [2:0] pnone  = {sd_ctrl_ff[`MAE_F_PRIO_LO +: 2] == `MAE_PRIO_NONE,
                       dg_ctrl_ff[`MAE_F_PRIO_LO +: 2] == `MAE_PRIO_NONE,
                       un_ctrl_ff[`MAE_F_PRIO_LO +: 2] == `MAE_PRIO_NONE};
  wire [2:0] any_evt = trip_evt | clr_evt;

  always @*
  begin
    nxt_alarm_log = any_evt & ~pnone;
    nxt_event_log = any_evt & pnone;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      relay_output_first_ff  <= 1'b0;
      relay_output_second_ff <= 1'b0;
      alarm_log_stb_ff       <= 3'h0;
      event_log_stb_ff       <= 3'h0;
      log_pickup_ff          <= 3'h0;
      alarm_indicate_ff      <= 1'b0;
      stat_ff                <= {`MAE_STAT_W{1'b0}};
    end
    else
    begin
      relay_output_first_ff  <= drive[0];
      relay_output_second_ff <= drive[1];
      alarm_log_stb_ff       <= nxt_alarm_log;
      event_log_stb_ff       <= nxt_event_log;
      log_pickup_ff          <= trip_evt;
      alarm_indicate_ff      <= |({sd_trip, dg_trip, un_trip_ff} & ~pnone);
      // New events win over a clear in the same cycle
      stat_ff <= (stat_ff & ~(wr_iclr ? wd[`MAE_STAT_W-1:0]
                                      : {`MAE_STAT_W{1'b0}})) |
                 {sd_reject, clr_evt, trip_evt};
    end
  end

  assign irq = |(stat_ff & ien_ff);

endmodule // mae_alarm_eval

// ==== tb/mae_field_model.sv ====
// Model of the monitored input pin and measurement source
`timescale 1ns/1ps
module mae_field_model (
  // Requested levels
  input  wire        dig_set,
  input  wire [31:0] meas_set,
  // Monitored signals
  output wire        dig_input_pin,
  output wire [31:0] meas_value
);
  // Pin edge lands off the clock grid, as a field wire would
  assign #3 dig_input_pin = dig_set;
  assign meas_value = meas_set;
endmodule // mae_field_model

// ==== tb/mae_alarm_eval_props.sv ====
// Port checker for the alarm evaluator
`timescale 1ns/1ps
module mae_alarm_eval_props (
  // Clock, reset, bus
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Alarm side
  input wire        basic_cfg_change,
  input wire        relay_output_first_ff,
  input wire [2:0]  alarm_log_stb_ff,
  input wire [2:0]  event_log_stb_ff
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
  write_block_a: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
  read_block_a: assert property
    (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r moved");
  read_cause_a: assert property ($rose(s_axi_rvalid)
    |-> $past(s_axi_arvalid && s_axi_arready)) else $error("r unasked");
  alarm_stb_pulse_a: assert property (
    alarm_log_stb_ff[1] |=> !alarm_log_stb_ff[1]) else $error("alarm stb");
  event_stb_pulse_a: assert property (
    event_log_stb_ff[2] |=> !event_log_stb_ff[2]) else $error("event stb");
  cfg_release_a: assert property (
    basic_cfg_change |-> ##[1:3] !relay_output_first_ff) else $error("relay");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($rose(relay_output_first_ff));
  cover property (event_log_stb_ff[2]);
endmodule // mae_alarm_eval_props

bind mae_alarm_eval mae_alarm_eval_props chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .basic_cfg_change(basic_cfg_change),
  .relay_output_first_ff(relay_output_first_ff),
  .alarm_log_stb_ff(alarm_log_stb_ff), .event_log_stb_ff(event_log_stb_ff));

// ==== tb/mae_alarm_eval_tb_top.sv ====
// Self-checking bench for the alarm evaluator
`timescale 1ns/1ps
`include "mae_regs.vh"
module mae_alarm_eval_tb_top;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg         uev, pcw, bcc, dig_set, pf;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, meas_set, rd;
  reg  [1:0]  rs;
  wire        awready, wready, bvalid, arready, rvalid, irq, pin, r1, r2;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata, meas;
  wire [2:0]  als, evs, lpk;
  wire        ind;
  integer     num_errors, checks, cyc, stdal, stdev, dgal;

  mae_field_model FM (.dig_set(dig_set), .meas_set(meas_set),
    .dig_input_pin(pin), .meas_value(meas));
  mae_alarm_eval #(.TICK_CYCLES(10)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .unary_event(uev),
    .dig_input_pin(pin), .meas_value(meas), .pf_lead(pf),
    .panel_cfg_write(pcw), .basic_cfg_change(bcc),
    .relay_output_first_ff(r1), .relay_output_second_ff(r2),
    .alarm_log_stb_ff(als), .event_log_stb_ff(evs), .log_pickup_ff(lpk),
    .alarm_indicate_ff(ind), .irq(irq));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ==========================================================
  // Tasks
  task end_of_test;
    begin
      if (num_errors == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (!bvalid)
      begin
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        @(posedge aclk);
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
    end
  endtask

  task rdt(input [7:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (!rvalid)
      begin
        if (arready) arvalid <= 1'b0;
        @(posedge aclk);
      end
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
    end
  endtask

  // Bounded wait, then compare the first relay
  task wait_r1(input v, input integer n);
    integer i;
    begin
      for (i = 0; i < n && r1 !== v; i = i + 1)
        @(posedge aclk);
      chk({31'h0, r1}, {31'h0, v});
    end
  endtask

  // One-cycle strobe on {uev, pcw, bcc}; drives the nets directly
  task pulse(input [2:0] m);
    begin
      {uev, pcw, bcc} <= m;
      @(posedge aclk);
      {uev, pcw, bcc} <= 3'h0;
    end
  endtask

  // ==========================================================
  // Watchdog and log strobe tallies
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (als[2]) stdal <= stdal + 1;
    if (evs[2]) stdev <= stdev + 1;
    // Digital alarm log: clear counts 1, pickup counts 16
    if (als[1]) dgal <= dgal + (lpk[1] ? 16 : 1);
    if (cyc == 5000)
    begin
      num_errors = num_errors + 1;
      end_of_test;
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {num_errors, checks, cyc, stdal, stdev, dgal} = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {uev, pcw, bcc, dig_set, pf, awaddr, araddr, wdata} = 0;
    meas_set = 32'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdt(`MAE_DIG_CTRL);
    chk(rd, 32'h0);
    rdt(8'h3c);
    chk({30'h0, rs}, 32'h2);
    wr(`MAE_STATE, 32'h1, 2'h2);
    wr(`MAE_DIG_PU_DLY, 32'h2, 2'h0);
    wr(`MAE_IRQ_ENABLE, 32'h2, 2'h0);
    wr(`MAE_DIG_CTRL, 32'h3f, 2'h0);
    dig_set <= 1'b1;
    repeat (22) @(posedge aclk);
    chk({31'h0, r1}, 32'h0);
    wait_r1(1'b1, 14);
    chk({29'h0, r2, irq, ind}, 32'h7);
    wr(`MAE_IRQ_CLEAR, 32'h2, 2'h0);
    chk({31'h0, irq}, 32'h0);
    dig_set <= 1'b0;
    wait_r1(1'b0, 16);
    dig_set <= 1'b1;
    wait_r1(1'b1, 40);
    pulse(3'h1);
    wait_r1(1'b0, 3);
    rdt(`MAE_DIG_CTRL);
    chk(rd, 32'h3e);
    repeat (40) @(posedge aclk);
    chk({31'h0, r1}, 32'h0);
    // Standard over alarm, 8 fraction bits, none priority, first relay
    wr(`MAE_STD_PU_LIM, 32'h6400, 2'h0);
    wr(`MAE_STD_DO_LIM, 32'hc800, 2'h0);
    wr(`MAE_STD_CTRL, 32'h9, 2'h2);
    rdt(`MAE_STD_CTRL);
    chk(rd, 32'h8);
    wr(`MAE_STD_DO_LIM, 32'h32ff, 2'h0);
    pulse(3'h2);
    rdt(`MAE_STD_DO_LIM);
    chk(rd, 32'h3200);
    wr(`MAE_STD_CTRL, 32'h9, 2'h0);
    meas_set <= 32'h6500;
    wait_r1(1'b1, 16);
    meas_set <= 32'h5000;
    repeat (30) @(posedge aclk);
    chk({30'h0, r1, ind}, 32'h2);
    meas_set <= 32'h3000;
    wait_r1(1'b0, 16);
    // Let the last strobe reach the tallies
    repeat (2) @(posedge aclk);
    chk(stdal, 32'h0);
    chk(stdev, 32'h2);
    chk(dgal, 32'h21);
    // Power-factor over alarm: pickup on lead only, dropout on lag only
    wr(`MAE_STD_CTRL, 32'hc9, 2'h0);
    meas_set <= 32'h6500;
    repeat (30) @(posedge aclk);
    chk({31'h0, r1}, 32'h0);
    pf <= 1'b1;
    wait_r1(1'b1, 16);
    meas_set <= 32'h3000;
    repeat (30) @(posedge aclk);
    chk({31'h0, r1}, 32'h1);
    pf <= 1'b0;
    wait_r1(1'b0, 16);
    // Unary normal drives nothing but still trips and ends at a tick
    wr(`MAE_IRQ_CLEAR, 32'h7f, 2'h0);
    wr(`MAE_UNARY_CTRL, 32'h19, 2'h0);
    pulse(3'h4);
    repeat (12) @(posedge aclk);
    chk({31'h0, r1}, 32'h0);
    rdt(`MAE_IRQ_STATUS);
    chk(rd, 32'h9);
    // Coil hold waits for acknowledge
    wr(`MAE_UNARY_CTRL, 32'h59, 2'h0);
    pulse(3'h4);
    wait_r1(1'b1, 4);
    wr(`MAE_UNARY_ACK, 32'h1, 2'h0);
    wait_r1(1'b0, 4);
    // Timed with hold 1: relay stays through one tick, drops at the next
    wr(`MAE_UNARY_HOLD, 32'h1, 2'h0);
    wr(`MAE_UNARY_CTRL, 32'h39, 2'h0);
    pulse(3'h4);
    wait_r1(1'b1, 4);
    repeat (9) @(posedge aclk);
    chk({31'h0, r1}, 32'h1);
    wait_r1(1'b0, 14);
    end_of_test;
  end
endmodule // mae_alarm_eval_tb_top
